// ==== arrow_monitor_pkg.sv ====
package arrow_monitor_pkg;
  // Clock and time base
  localparam int CLK_HZ = 250_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int FLASH_MS = 1500; // Between the 1400 and 1600 limits
  localparam int DUAL_MS = 350; // Between the 200 and 500 limits
  localparam int RED_MS = 1350; // Red fail persistence
  localparam int CLEAR_MS = 2700; // Least solid yellow time
  localparam int SEQ_MS = 50; // Sequence log sample period
  localparam int SEC_MS = 1000; // Time-of-day tick
  localparam int BAUD_RATE = 9600; // Serial bit rate
  localparam int CNT_W = 30; // Holds 2700 ms of cycles
  // Channel layout
  localparam int NCH = 16; // Monitored channels
  localparam int ARROW_BASE = 8; // First arrow channel
  localparam int ENT_W = 56 + 3 * NCH; // Event entry width
  localparam int ENT_BYTES = ENT_W / 8; // Bytes sent per entry
  localparam int SEQ_W = 3 * NCH + 1; // Sequence sample width
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_TIME = 8'h08;
  localparam logic [7:0] A_DATE = 8'h0C;
  localparam logic [7:0] A_SEQ_SEL = 8'h10;
  localparam logic [7:0] A_SEQ_LO = 8'h14;
  localparam logic [7:0] A_SEQ_HI = 8'h18;
  localparam int CTRL_DUMP_BIT = 4; // Write one to dump
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Event codes kept in the log
  localparam logic [3:0] EV_CONFLICT = 4'h1;
  localparam logic [3:0] EV_YEL_CONFLICT = 4'h2;
  localparam logic [3:0] EV_FLASH_RATE = 4'h3;
  localparam logic [3:0] EV_RED_FAIL = 4'h4;
  localparam logic [3:0] EV_DUAL = 4'h5;
  localparam logic [3:0] EV_CLEARANCE = 4'h6;
  localparam logic [3:0] EV_RESET = 4'h7;
  localparam logic [3:0] EV_CONFIG = 4'h8;
  localparam logic [3:0] EV_PREV_FAULT = 4'h9;
  localparam logic [3:0] EV_AC_LINE = 4'hA;
  // Serial engine states
  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SEND} tx_st_t;
endpackage : arrow_monitor_pkg

// ==== arrow_monitor_props.sv ====
`timescale 1ns/1ps
module arrow_monitor_props (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic front_reset_in, // Panel reset
  input wire logic remote_reset_in, // Remote reset
  input wire logic tx_data, // Serial out
  input wire logic dcd_out, // Dump running
  input wire logic dsr_out, // Device ready
  input wire logic rts_out, // Ready to receive
  input wire logic fault_out, // Latched fault
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid // Read data valid
);
  logic rst_any; // Either reset source
  assign rst_any = front_reset_in || remote_reset_in;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Bus handshakes as steps
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_ready;
    $past(rst_n) |-> dsr_out && rts_out;
  endproperty
  a_ready: assert property (p_ready) else $error("dsr or rts low");
  property p_tx_idle;
    !dcd_out |-> tx_data;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("tx not idle");
  property p_tx_frame;
    $fell(tx_data) |-> dcd_out;
  endproperty
  a_tx_frame: assert property (p_tx_frame) else $error("start bit outside dump");
  // Hold demanded once reset input is quiet
  property p_latch;
    fault_out && !rst_any && !$past(rst_any) && !$past(rst_any, 2) |=> fault_out;
  endproperty
  a_latch: assert property (p_latch) else $error("fault dropped");
  property p_clear;
    $rose(rst_any) |-> ##[1:3] !fault_out;
  endproperty
  a_clear: assert property (p_clear) else $error("fault not cleared");
  property p_rd_lat;
    s_rd |-> ##[1:2] s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat;
    s_wr |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
endmodule : arrow_monitor_props
bind arrow_pair_fault_monitor arrow_monitor_props props (.mclk(mclk), .rst_n(rst_n),
  .front_reset_in(front_reset_in), .remote_reset_in(remote_reset_in), .tx_data(tx_data),
  .dcd_out(dcd_out), .dsr_out(dsr_out), .rts_out(rts_out), .fault_out(fault_out),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// ==== arrow_pair_fault_monitor.sv ====
`timescale 1ns/1ps
module arrow_pair_fault_monitor
  import arrow_monitor_pkg::*;
#(
  parameter int NPAIR = 4, // Arrow channel pairs
  parameter int LOG_DEPTH = 9, // Event log entries
  parameter int SEQ_DEPTH = 41, // Samples, just over 2 s
  parameter int unsigned FLASH_CYC = FLASH_MS * CYC_PER_MS, // Flash trip count
  parameter int unsigned DUAL_CYC = DUAL_MS * CYC_PER_MS, // Dual trip count
  parameter int unsigned RED_CYC = RED_MS * CYC_PER_MS, // Red fail trip count
  parameter int unsigned CLEAR_CYC = CLEAR_MS * CYC_PER_MS, // Least yellow count
  parameter int unsigned SEQ_CYC = SEQ_MS * CYC_PER_MS, // Sample period count
  parameter int unsigned SEC_CYC = SEC_MS * CYC_PER_MS, // One second count
  parameter int unsigned BAUD_CYC = CLK_HZ / BAUD_RATE // One serial bit
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [NCH-1:0] green_in, // Qualified green on states
  input wire logic [NCH-1:0] yellow_in, // Qualified yellow on states
  input wire logic [NCH-1:0] red_in, // Qualified red on states
  input wire logic [NCH*NCH-1:0] compat_in, // Compatibility, bit i*NCH+j
  input wire logic red_gate_in, // Red monitor gate active
  input wire logic special_func1_in, // Special function 1 active
  input wire logic special_func2_in, // Special function 2 active
  input wire logic relay_common_input, // Relay common active
  input wire logic flash_jumper_in, // Jumper fitted
  input wire logic front_reset_in, // Front panel reset
  input wire logic remote_reset_in, // External remote reset
  input wire logic ac_fail_in, // AC line below drop-out
  input wire logic rx_data, // Serial receive, not used
  input wire logic dtr_in, // Rise starts a dump
  input wire logic cts_in, // Host allows sending
  output logic tx_data, // Serial transmit
  output logic dcd_out, // High while a dump runs
  output logic dsr_out, // Device ready
  output logic rts_out, // Ready to receive
  output logic fault_out, // Latched fault trigger
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  // Trip counts at counter width
  localparam logic [CNT_W-1:0] FLASH_N = CNT_W'(FLASH_CYC);
  localparam logic [CNT_W-1:0] DUAL_N = CNT_W'(DUAL_CYC);
  localparam logic [CNT_W-1:0] RED_N = CNT_W'(RED_CYC);
  localparam logic [CNT_W-1:0] CLEAR_N = CNT_W'(CLEAR_CYC);
  localparam logic [CNT_W-1:0] SEQ_N = CNT_W'(SEQ_CYC - 1);
  localparam logic [CNT_W-1:0] SEC_N = CNT_W'(SEC_CYC - 1);
  localparam logic [15:0] BAUD_N = 16'(BAUD_CYC - 1);
  localparam int LW = $clog2(LOG_DEPTH + 1);
  localparam int SW = $clog2(SEQ_DEPTH);

  // Whole module state
  typedef struct packed {
    logic aw_hold; // Write address taken
    logic w_hold; // Write data taken
    logic [7:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [NPAIR-1:0] pair_en; // Pairs in arrow operation
    logic [31:0] secs; // Seconds count
    logic [15:0] date; // Day number
    logic [SW-1:0] seq_sel; // Sequence read index
    logic fault; // Latched trigger
    logic [3:0] ftype;
    logic [NPAIR-1:0] fpairs;
    logic [NPAIR-1:0][CNT_W-1:0] flash_cnt;
    logic [NPAIR-1:0][CNT_W-1:0] dual_cnt;
    logic [NPAIR-1:0][CNT_W-1:0] red_cnt;
    logic [NPAIR-1:0][CNT_W-1:0] yel_cnt;
    logic [NPAIR-1:0] grn_pend; // Green awaiting yellow
    logic [NPAIR-1:0] prot_last; // Last interval was protected
    logic [NPAIR-1:0] yel_timing;
    logic [NPAIR-1:0] prev_ya;
    logic [CNT_W-1:0] sec_cnt;
    logic [CNT_W-1:0] seq_cnt;
    logic [LOG_DEPTH-1:0][ENT_W-1:0] log_mem;
    logic [LW-1:0] log_wr;
    logic [LW-1:0] log_cnt;
    logic [SEQ_DEPTH-1:0][SEQ_W-1:0] seq_mem;
    logic [SW-1:0] seq_wr;
    logic frozen; // History held after a trip
    logic [NCH*NCH+NPAIR:0] cfg_prev; // Last seen configuration
    logic ac_prev;
    logic rst_prev;
    logic dtr_prev;
    tx_st_t tx_st;
    logic [LW-1:0] ent_left;
    logic [LW-1:0] ent_idx;
    logic [ENT_W-1:0] shreg;
    logic [3:0] byte_left;
    logic [9:0] frame;
    logic [3:0] nbit;
    logic [15:0] baud;
    logic tx_space; // Inverted line, zero is idle
    logic ready; // DSR and RTS after reset
  } state_t;

  state_t s; // Registered state
  state_t next_s; // Next state

  // Compatibility row of one channel
  function automatic logic [NCH-1:0] row_of(input logic [NCH*NCH-1:0] m, input int c);
    row_of = m[c*NCH +: NCH];
  endfunction : row_of

  // Byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) merge[8*b +: 8] = d[8*b +: 8];
    end
  endfunction : merge

  // Wrapping log index step
  function automatic logic [LW-1:0] log_inc(input logic [LW-1:0] i);
    log_inc = (i == LW'(LOG_DEPTH - 1)) ? '0 : i + 1'b1;
  endfunction : log_inc

  // Decoding, checks, logs and serial engine
  always_comb begin
    logic [NCH-1:0] act;
    logic [NCH-1:0] row;
    logic ra, ya, fa, ga, mon_gate, red_mon, trip, wr_ev;
    logic [3:0] ev_code;
    logic [3:0] trip_code;
    logic [NPAIR-1:0] trip_pairs;
    logic [NPAIR-1:0] ev_pairs;
    logic [SW-1:0] phys;
    logic [NCH*NCH+NPAIR:0] cfg_now;
    logic dump_req;
    int fc, gc;
    act = green_in | yellow_in;
    row = '0;
    ra = 1'b0;
    ya = 1'b0;
    fa = 1'b0;
    ga = 1'b0;
    trip = 1'b0;
    wr_ev = 1'b0;
    ev_code = '0;
    trip_code = '0;
    trip_pairs = '0;
    ev_pairs = '0;
    phys = '0;
    fc = 0;
    gc = 0;
    dump_req = 1'b0;
    next_s = s;
    next_s.ready = 1'b1;
    // Gates shared by red, dual and clearance checks
    mon_gate = red_gate_in & ~relay_common_input;
    red_mon = mon_gate & ~special_func1_in & ~special_func2_in;

    // Time of day tick
    next_s.sec_cnt = s.sec_cnt + 1'b1;
    if (s.sec_cnt == SEC_N) begin
      next_s.sec_cnt = '0;
      next_s.secs = s.secs + 1'b1;
    end

    // Conflict among all channels
    for (int i = 0; i < NCH; i++) begin
      if (act[i] && |(act & ~row_of(compat_in, i) & ~(NCH'(1) << i))) begin
        trip = 1'b1;
        trip_code = EV_CONFLICT;
      end
    end

    // Per-pair arrow checks
    for (int p = 0; p < NPAIR; p++) begin
      fc = ARROW_BASE + p;
      gc = 2 * p;
      ra = red_in[fc];
      ya = yellow_in[fc];
      fa = green_in[fc];
      ga = green_in[gc];
      next_s.prev_ya[p] = ya;
      if (!s.pair_en[p]) begin
        next_s.flash_cnt[p] = '0;
        next_s.dual_cnt[p] = '0;
        next_s.red_cnt[p] = '0;
        next_s.grn_pend[p] = 1'b0;
        next_s.yel_timing[p] = 1'b0;
      end else begin
        // Yellow conflict, row chosen by last interval
        row = s.prot_last[p] ? row_of(compat_in, gc) : row_of(compat_in, fc);
        if (ya && |(act & ~row & ~(NCH'(1) << fc) & ~(NCH'(1) << gc))) begin
          trip = 1'b1;
          trip_code = EV_YEL_CONFLICT;
          trip_pairs[p] = 1'b1;
        end
        // Flash watchdog, one on period at a time
        if (fa && flash_jumper_in) begin
          next_s.flash_cnt[p] = s.flash_cnt[p] + 1'b1;
          if (s.flash_cnt[p] >= FLASH_N) begin
            trip = 1'b1;
            trip_code = EV_FLASH_RATE;
            trip_pairs[p] = 1'b1;
          end
        end else begin
          next_s.flash_cnt[p] = '0;
        end
        // No arrow indication
        if (red_mon && !(ra | ya | fa | ga)) begin
          next_s.red_cnt[p] = s.red_cnt[p] + 1'b1;
          if (s.red_cnt[p] >= RED_N) begin
            trip = 1'b1;
            trip_code = EV_RED_FAIL;
            trip_pairs[p] = 1'b1;
          end
        end else begin
          next_s.red_cnt[p] = '0;
        end
        // Two or more indications
        if (mon_gate && (2'(ra) + 2'(ya) + 2'(fa) + 2'(ga) >= 2'd2 ||
                         (ra & ya & fa & ga))) begin
          next_s.dual_cnt[p] = s.dual_cnt[p] + 1'b1;
          if (s.dual_cnt[p] >= DUAL_N) begin
            trip = 1'b1;
            trip_code = EV_DUAL;
            trip_pairs[p] = 1'b1;
          end
        end else begin
          next_s.dual_cnt[p] = '0;
        end
        // Clearance; flash off phases end no interval
        // Only yellow or red ends a green interval
        if (ga || fa) begin
          next_s.grn_pend[p] = 1'b1;
          next_s.prot_last[p] = ga;
        end else if (ya && !s.prev_ya[p] && s.grn_pend[p]) begin
          next_s.grn_pend[p] = 1'b0;
          next_s.yel_timing[p] = 1'b1;
          next_s.yel_cnt[p] = '0;
        end else if (ra && s.grn_pend[p]) begin
          next_s.grn_pend[p] = 1'b0;
          if (mon_gate) begin // Missing yellow
            trip = 1'b1;
            trip_code = EV_CLEARANCE;
            trip_pairs[p] = 1'b1;
          end
        end
        if (s.yel_timing[p]) begin
          if (ya) begin
            next_s.yel_cnt[p] = s.yel_cnt[p] + 1'b1;
          end else begin
            next_s.yel_timing[p] = 1'b0;
            if (mon_gate && s.yel_cnt[p] < CLEAR_N) begin
              trip = 1'b1;
              trip_code = EV_CLEARANCE;
              trip_pairs[p] = 1'b1;
            end
          end
        end
      end
    end

    // Latch first trip, freeze history
    next_s.rst_prev = front_reset_in | remote_reset_in;
    if (trip && !s.fault) begin
      next_s.fault = 1'b1;
      next_s.ftype = trip_code;
      next_s.fpairs = trip_pairs;
      next_s.frozen = 1'b1;
      wr_ev = 1'b1;
      ev_code = trip_code;
      ev_pairs = trip_pairs;
    end else if ((front_reset_in | remote_reset_in) && !s.rst_prev) begin
      next_s.fault = 1'b0;
      next_s.frozen = 1'b0;
      wr_ev = 1'b1;
      ev_code = s.fault ? EV_PREV_FAULT : EV_RESET;
      ev_pairs = s.fpairs;
    end

    // Config and AC line events, lower priority
    cfg_now = {flash_jumper_in, s.pair_en, compat_in};
    next_s.ac_prev = ac_fail_in;
    if (cfg_now != s.cfg_prev && !wr_ev) begin
      next_s.cfg_prev = cfg_now;
      wr_ev = 1'b1;
      ev_code = EV_CONFIG;
    end else if (ac_fail_in != s.ac_prev && !wr_ev) begin
      wr_ev = 1'b1;
      ev_code = EV_AC_LINE;
    end

    // Ring of nine newest entries
    if (wr_ev) begin
      next_s.log_mem[s.log_wr] = {s.date, s.secs, ev_code, ev_pairs,
                                  red_in, yellow_in, green_in};
      next_s.log_wr = log_inc(s.log_wr);
      if (s.log_cnt != LW'(LOG_DEPTH)) next_s.log_cnt = s.log_cnt + 1'b1;
    end

    // Sequence history sampling
    next_s.seq_cnt = s.seq_cnt + 1'b1;
    if (s.seq_cnt == SEQ_N) begin
      next_s.seq_cnt = '0;
      if (!s.frozen) begin
        next_s.seq_mem[s.seq_wr] = {red_gate_in, red_in, yellow_in, green_in};
        next_s.seq_wr = (s.seq_wr == SW'(SEQ_DEPTH - 1)) ? '0 : s.seq_wr + 1'b1;
      end
    end

    // Writes once address and data are held
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_hold = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_hold = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.aw_hold && s.w_hold) begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      case (s.aw_addr)
        A_CTRL: begin
          next_s.pair_en = NPAIR'(merge(32'(s.pair_en), s.wdata, s.wstrb));
          dump_req = s.wstrb[0] & s.wdata[CTRL_DUMP_BIT];
        end
        A_TIME: next_s.secs = merge(s.secs, s.wdata, s.wstrb);
        A_DATE: next_s.date = 16'(merge(32'(s.date), s.wdata, s.wstrb));
        A_SEQ_SEL: next_s.seq_sel = SW'(merge(32'(s.seq_sel), s.wdata, s.wstrb));
        A_STATUS, A_SEQ_LO, A_SEQ_HI: next_s.bresp = RESP_OKAY; // Read only
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    if (s.bvalid && s_axi_bready) next_s.bvalid = 1'b0;

    // Reads, answered the cycle after
    phys = (s.seq_sel < SW'(SEQ_DEPTH)) ? s.seq_sel : '0;
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = '0;
      case (s_axi_araddr)
        A_CTRL: next_s.rdata = 32'(s.pair_en);
        A_STATUS: next_s.rdata = {10'h000, 6'(s.seq_wr), 1'b0, s.tx_st != TX_IDLE,
                                  s.frozen, 4'(s.log_cnt), 4'(s.fpairs), s.ftype, s.fault};
        A_TIME: next_s.rdata = s.secs;
        A_DATE: next_s.rdata = 32'(s.date);
        A_SEQ_SEL: next_s.rdata = 32'(s.seq_sel);
        A_SEQ_LO: next_s.rdata = s.seq_mem[phys][31:0];
        A_SEQ_HI: next_s.rdata = 32'(s.seq_mem[phys][SEQ_W-1:32]);
        default: next_s.rresp = RESP_SLVERR;
      endcase
    end
    if (s.rvalid && s_axi_rready) next_s.rvalid = 1'b0;

    // Serial log dump, oldest first, paced by CTS
    next_s.dtr_prev = dtr_in;
    dump_req = dump_req | (dtr_in & ~s.dtr_prev);
    case (s.tx_st)
      TX_IDLE: begin
        if (dump_req && s.log_cnt != '0) begin
          next_s.ent_left = s.log_cnt;
          next_s.ent_idx = (s.log_cnt == LW'(LOG_DEPTH)) ? s.log_wr : '0;
          next_s.tx_st = TX_LOAD;
        end
      end
      TX_LOAD: begin
        if (s.ent_left == '0) begin
          next_s.tx_st = TX_IDLE;
        end else begin
          next_s.shreg = s.log_mem[s.ent_idx];
          next_s.ent_idx = log_inc(s.ent_idx);
          next_s.ent_left = s.ent_left - 1'b1;
          next_s.byte_left = 4'(ENT_BYTES);
          next_s.nbit = '0;
          next_s.tx_st = TX_SEND;
        end
      end
      TX_SEND: begin
        if (s.baud != '0) begin
          next_s.baud = s.baud - 1'b1;
        end else if (s.nbit != '0) begin
          next_s.tx_space = ~s.frame[0];
          next_s.frame = {1'b1, s.frame[9:1]};
          next_s.nbit = s.nbit - 1'b1;
          next_s.baud = BAUD_N;
        end else if (s.byte_left == '0) begin
          next_s.tx_st = TX_LOAD;
        end else if (cts_in) begin // Host flow control
          next_s.frame = {1'b1, s.shreg[ENT_W-1 -: 8], 1'b0};
          next_s.shreg = {s.shreg[ENT_W-9:0], 8'h00};
          next_s.byte_left = s.byte_left - 1'b1;
          next_s.nbit = 4'd10;
        end
      end
      default: next_s.tx_st = TX_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign s_axi_awready = ~s.aw_hold & ~s.bvalid;
  assign s_axi_wready = ~s.w_hold & ~s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = ~s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign tx_data = ~s.tx_space;
  assign dcd_out = s.tx_st != TX_IDLE;
  assign dsr_out = s.ready;
  assign rts_out = s.ready;
  assign fault_out = s.fault;
endmodule : arrow_pair_fault_monitor

// ==== arrow_pair_fault_monitor_tb.sv ====
`timescale 1ns/1ps
module arrow_pair_fault_monitor_tb;
  import arrow_monitor_pkg::*;
  localparam int BAUD = 4; // Short bit, brief dump
  logic mclk = 0, rst_n = 0, red_gate_in = 0, relay_common_input = 0, flash_jumper_in = 0;
  logic [NCH-1:0] green_in = '0, yellow_in = '0, red_in = '1; // All channels red
  logic front_reset_in = 0, remote_reset_in = 0, ac_fail_in = 0, dtr_in = 0, sf_in = 0;
  logic cts_in, tx_data, dcd_out, dsr_out, rts_out, fault_out;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int mismatches = 0, samples_checked = 0, nbytes, nbad;
  always #2 mclk = ~mclk;
  arrow_pair_fault_monitor #(.FLASH_CYC(50), .DUAL_CYC(20), .RED_CYC(30), .CLEAR_CYC(100),
    .SEQ_CYC(10), .SEC_CYC(100), .BAUD_CYC(BAUD)) dut (.mclk(mclk), .rst_n(rst_n),
    .green_in(green_in), .yellow_in(yellow_in), .red_in(red_in), .compat_in({256{1'b1}}),
    .red_gate_in(red_gate_in), .special_func1_in(sf_in), .special_func2_in(sf_in),
    .relay_common_input(relay_common_input), .flash_jumper_in(flash_jumper_in),
    .front_reset_in(front_reset_in), .remote_reset_in(remote_reset_in), .ac_fail_in(ac_fail_in),
    .rx_data(1'b1), .dtr_in(dtr_in), .cts_in(cts_in), .tx_data(tx_data), .dcd_out(dcd_out),
    .dsr_out(dsr_out), .rts_out(rts_out), .fault_out(fault_out), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  serial_host #(.BAUD(BAUD)) host (.mclk(mclk), .tx_data(tx_data), .cts(cts_in),
    .nbytes(nbytes), .nbad(nbad));
  // Verdict
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tmo;
    chk("wait", 0, 1);
    end_sim();
  endtask : tmo
  // Ready is sampled mid-cycle, where it is settled
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge mclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (int n = 0; !(ad && wd); n++) begin
      if (n == 50) tmo();
      @(negedge mclk);
      ad = ad || s_axi_awready === 1'b1;
      wd = wd || s_axi_wready === 1'b1;
      @(posedge mclk);
      if (ad) s_axi_awvalid <= 0;
      if (wd) s_axi_wvalid <= 0;
    end
    for (int n = 0; s_axi_bvalid !== 1'b1; n++) begin
      if (n == 50) tmo();
      @(negedge mclk);
    end
    rsp = s_axi_bresp;
    @(posedge mclk);
    s_axi_bready <= 0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge mclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    for (int n = 0; s_axi_arready !== 1'b1; n++) begin
      if (n == 50) tmo();
      @(negedge mclk);
    end
    @(posedge mclk);
    s_axi_arvalid <= 0;
    for (int n = 0; s_axi_rvalid !== 1'b1; n++) begin
      if (n == 50) tmo();
      @(negedge mclk);
    end
    {rd, rsp} = {s_axi_rdata, s_axi_rresp};
    @(posedge mclk);
    s_axi_rready <= 0;
  endtask : axi_rd
  // Pair 0 red, yellow, flashing for n cycles
  task automatic arrow(input logic r, input logic y, input logic f, input int n);
    @(posedge mclk);
    {red_in[ARROW_BASE], yellow_in[ARROW_BASE], green_in[ARROW_BASE]} <= {r, y, f};
    repeat (n) @(posedge mclk);
  endtask : arrow
  task automatic trip(input logic [3:0] code);
    chk("fault", fault_out, 1);
    axi_rd(A_STATUS);
    chk("type", rd[4:1], code);
    @(posedge mclk);
    front_reset_in <= 1;
    repeat (2) @(posedge mclk);
    front_reset_in <= 0;
    repeat (4) @(posedge mclk);
    chk("cleared", fault_out, 0);
  endtask : trip
  task automatic t_bus;
    chk("ready", {dsr_out, rts_out, tx_data, fault_out}, 4'b1110);
    axi_rd(8'h40);
    chk("rd_resp", {rd, rsp}, {32'h0000_0000, RESP_SLVERR});
    axi_wr(8'h40, 32'h0000_0001);
    chk("wr_resp", rsp, RESP_SLVERR);
    axi_wr(A_CTRL, 32'h0000_0001);
    axi_rd(A_CTRL);
    chk("pair_en", rd[3:0], 4'h1);
    $display("bus test done");
  endtask : t_bus
  task automatic t_flash;
    arrow(0, 0, 1, 60);
    arrow(0, 1, 0, 110);
    arrow(1, 0, 0, 5);
    chk("jumper_off", fault_out, 0);
    flash_jumper_in <= 1;
    repeat (2) begin
      arrow(0, 0, 1, 40);
      arrow(0, 0, 0, 5); // Restart discards earlier on time
    end
    chk("short_flash", fault_out, 0);
    arrow(0, 0, 1, 60);
    arrow(0, 1, 0, 110);
    arrow(1, 0, 0, 30);
    trip(EV_FLASH_RATE);
    $display("flash test done");
  endtask : t_flash
  task automatic t_pair;
    red_gate_in <= 1;
    arrow(1, 1, 0, 5);
    arrow(1, 0, 0, 5);
    chk("short_dual", fault_out, 0);
    arrow(1, 1, 0, 30);
    arrow(1, 0, 0, 5);
    trip(EV_DUAL);
    relay_common_input <= 1;
    arrow(0, 0, 0, 50);
    chk("red_gated", fault_out, 0);
    {relay_common_input, sf_in} <= 2'b01;
    arrow(0, 0, 0, 50);
    chk("sf_gated", fault_out, 0);
    sf_in <= 0;
    arrow(0, 0, 0, 50);
    arrow(1, 0, 0, 5);
    trip(EV_RED_FAIL);
    arrow(0, 0, 1, 10);
    arrow(0, 1, 0, 50);
    arrow(1, 0, 0, 5);
    trip(EV_CLEARANCE);
    $display("pair test done");
  endtask : t_pair
  task automatic t_log;
    repeat (10) begin
      ac_fail_in <= ~ac_fail_in;
      repeat (10) @(posedge mclk);
    end
    axi_rd(A_STATUS);
    chk("log_count", rd[12:9], 4'd9);
    dtr_in <= 1;
    for (int n = 0; dcd_out !== 1'b1; n++) begin
      if (n == 50) tmo();
      @(posedge mclk);
    end
    for (int n = 0; dcd_out !== 1'b0; n++) begin
      if (n == 9000) tmo();
      @(posedge mclk);
    end
    repeat (4 * BAUD) @(posedge mclk);
    chk("bytes", nbytes, 9 * ENT_BYTES);
    chk("framing", nbad, 0);
    $display("log test done");
  endtask : t_log
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1;
    repeat (3) @(posedge mclk);
    t_bus();
    t_flash();
    t_pair();
    t_log();
    end_sim();
  end
endmodule : arrow_pair_fault_monitor_tb

// ==== serial_host.sv ====
`timescale 1ns/1ps
module serial_host #(
  parameter int BAUD = 4 // Cycles per bit
) (
  input wire logic mclk, // System clock
  input wire logic tx_data, // Bytes from the monitor
  output logic cts, // Clear to send
  output int nbytes, // Bytes received
  output int nbad // Framing errors
);
  // 8N1 receiver; stalls cts after every fifth byte
  initial begin
    cts = 1;
    nbytes = 0;
    nbad = 0;
    forever begin
      @(negedge tx_data);
      repeat (BAUD / 2) @(posedge mclk);
      if (tx_data !== 1'b0) nbad++;
      repeat (9 * BAUD) @(posedge mclk);
      if (tx_data !== 1'b1) nbad++;
      nbytes++;
      if (nbytes % 5 == 0) begin
        cts <= 0;
        repeat (20) @(posedge mclk);
        cts <= 1;
      end
    end
  end
endmodule : serial_host
